//--- include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] result_offset  = 8'hd0;
  localparam logic [7:0] control_offset = 8'hd1;
  localparam logic [7:0] status_offset  = 8'hd2;
  localparam logic [7:0] mask_offset    = 8'hd3;

  // ==========================================================================
  // control field positions
  localparam int irq_enable_bit   = 7;
  localparam int end_conv_bit     = 6;
  localparam int start_bit        = 5;
  localparam int power_select_bit = 4;
  localparam int reserved_3_bit   = 3;
  localparam int osc_disable_bit  = 2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] control_reset = 8'h40;
  localparam logic [7:0] result_reset  = 8'h00;
  localparam logic [1:0] status_reset  = 2'h0;
  localparam logic [1:0] mask_reset    = 2'h0;

  // ==========================================================================
  // status/mask events: bit 0 conversion done, bit 1 conversion abandoned by a new start while busy
  localparam int ev_done    = 0;
  localparam int ev_restart = 1;

  // ==========================================================================
  // timing: conversion time at the system clock
  localparam int  clk_hz        = 20000000;
  localparam int  conv_time_us  = 70;
  localparam int  conv_cycles   = (conv_time_us * (clk_hz / 1000000));
  localparam int  result_bits   = 8;
  localparam int  step_cycles_i = conv_cycles / result_bits;
  localparam logic [7:0] step_cycles = 8'(step_cycles_i);

  typedef enum logic [1:0] {idle_st, sample_st, done_st} conv_state_type;

endpackage

//--- hdl/adc_step_timer.sv
`timescale 1ns/1ns
// step pacing: one enable pulse every step_cycles while running
module adc_step_timer (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic restart,
  input  wire logic run,
  output logic      step_en
);

  logic [7:0] count_q;

  // ==========================================================================
  // divider
  always_ff @(posedge clk) begin
    if (!rst_b || restart || !run) begin
      count_q <= 8'h00;
    end else if (count_q == adc_ctrl_pkg::step_cycles - 8'h01) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  assign step_en = run && !restart && (count_q == adc_ctrl_pkg::step_cycles - 8'h01);

endmodule

//--- hdl/adc_sar_core.sv
`timescale 1ns/1ns
// successive approximation register, msb first
module adc_sar_core (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       begin_conv,
  input  wire logic       step_en,
  input  wire logic       comp_high,
  output logic [7:0]      trial_code,
  output logic            finished
);

  logic [7:0] code_q;
  logic [7:0] probe_q;

  // ==========================================================================
  // bit trial and decision
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_q  <= 8'h00;
      probe_q <= 8'h00;
    end else if (begin_conv) begin
      code_q  <= 8'h80;
      probe_q <= 8'h80;
    end else if (step_en && probe_q != 8'h00) begin
      if (!comp_high) begin
        code_q <= (code_q & ~probe_q) | (probe_q >> 1); // drop trial bit
      end else begin
        code_q <= code_q | (probe_q >> 1); // keep trial bit
      end
      probe_q <= probe_q >> 1;
    end
  end

  assign trial_code = code_q;
  assign finished   = step_en && (probe_q == 8'h01);

endmodule

//--- hdl/adc_control.sv
`timescale 1ns/1ns
// Behaviour
// - one conversion per start write; no continuous mode.
// - start during a conversion abandons it and starts afresh.
// - start bit 5 write-only; writing 0 ignored; reads zero.
// - completion sets done flag bit 6; interrupt if enable bit 7 set.
// - start write clears done flag and pending interrupt.
// - done flag read-only; writing zero does not clear it.
// - result valid only while done flag is one.
// - power bit 4 turns converter on; stop mode forces off.
// - wait mode unaffected; done interrupt wakes from wait, not stop.
// - control bit 2 disables main oscillator; clock system function.
// - eight-bit result in read-only register at d0.
// - control register at d1 resets to 40.
// - conversion takes about 70 microseconds from start to flag.
module adc_control (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic       comp_high,
  output logic [7:0]      dac_code,
  output logic            conv_power_on,
  output logic            sample_active,
  output logic            main_osc_disable,
  input  wire logic       wait_mode,
  input  wire logic       stop_mode,
  output logic            conv_irq,
  output logic            wake_request,
  output logic            irq
);

  logic       conv_irq_enable_q;
  logic       end_conv_q;
  logic       conv_power_select_q;
  logic       control_reserved_3_q;
  logic       main_osc_disable_q;
  logic [1:0] control_reserved_lo_q;
  logic [7:0] result_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] rdata_q;
  logic       busy_q;
  logic       stop_sync1_q;
  logic       stop_sync2_q;
  logic       stop_sync3_q;
  logic       stop_q;
  logic       ctrl_wr;
  logic       conv_start;
  logic       powered;
  logic       step_en;
  logic       finished;
  logic [7:0] trial_code;
  logic [7:0] control_view;
  adc_ctrl_pkg::conv_state_type state_q;

  // ==========================================================================
  // stop mode input, three-stage synchroniser, change once stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_sync1_q <= 1'b0;
      stop_sync2_q <= 1'b0;
      stop_sync3_q <= 1'b0;
      stop_q       <= 1'b0;
    end else begin
      stop_sync1_q <= stop_mode;
      stop_sync2_q <= stop_sync1_q;
      stop_sync3_q <= stop_sync2_q;
      if (stop_sync2_q == stop_sync3_q) begin
        stop_q <= stop_sync3_q;
      end
    end
  end

  // ==========================================================================
  // decode
  assign ctrl_wr    = wr && (addr == adc_ctrl_pkg::control_offset);
  assign conv_start = ctrl_wr && wdata[adc_ctrl_pkg::start_bit];
  assign powered    = conv_power_select_q && !stop_q;

  // ==========================================================================
  // control register fields
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_irq_enable_q     <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::irq_enable_bit];
      conv_power_select_q   <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::power_select_bit];
      control_reserved_3_q  <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::reserved_3_bit];
      main_osc_disable_q    <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::osc_disable_bit];
      control_reserved_lo_q <= adc_ctrl_pkg::control_reset[1:0];
    end else if (ctrl_wr) begin
      conv_irq_enable_q     <= wdata[adc_ctrl_pkg::irq_enable_bit];
      conv_power_select_q   <= wdata[adc_ctrl_pkg::power_select_bit];
      control_reserved_3_q  <= wdata[adc_ctrl_pkg::reserved_3_bit];
      main_osc_disable_q    <= wdata[adc_ctrl_pkg::osc_disable_bit];
      control_reserved_lo_q <= wdata[1:0];
    end
  end

  // ==========================================================================
  // interrupt mask register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_q <= adc_ctrl_pkg::mask_reset;
    end else if (wr && addr == adc_ctrl_pkg::mask_offset) begin
      mask_q <= wdata[1:0];
    end
  end

  // ==========================================================================
  // conversion sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= adc_ctrl_pkg::idle_st;
      busy_q  <= 1'b0;
    end else if (conv_start && powered) begin
      state_q <= adc_ctrl_pkg::sample_st;
      busy_q  <= 1'b1;
    end else if (!powered) begin
      state_q <= adc_ctrl_pkg::idle_st; // converter off abandons work
      busy_q  <= 1'b0;
    end else begin
      case (state_q)
        adc_ctrl_pkg::sample_st: begin
          if (finished) begin
            state_q <= adc_ctrl_pkg::done_st;
            busy_q  <= 1'b0;
          end
        end
        adc_ctrl_pkg::done_st: begin
          state_q <= adc_ctrl_pkg::idle_st;
        end
        default: begin
          state_q <= adc_ctrl_pkg::idle_st;
        end
      endcase
    end
  end

  // ==========================================================================
  // end-of-conversion flag: start clears, completion sets, writes of 0 ignored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      end_conv_q <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::end_conv_bit];
    end else if (conv_start) begin
      end_conv_q <= 1'b0;
    end else if (finished && busy_q && powered) begin
      end_conv_q <= 1'b1;
    end
  end

  // ==========================================================================
  // result register, loaded on the final step
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result_q <= adc_ctrl_pkg::result_reset;
    end else if (finished && busy_q && powered && !conv_start) begin
      result_q <= {trial_code[7:1], comp_high};
    end
  end

  // ==========================================================================
  // sticky event status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= adc_ctrl_pkg::status_reset;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && addr == adc_ctrl_pkg::status_offset && wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
      if (finished && busy_q && powered && !conv_start) begin
        status_q[adc_ctrl_pkg::ev_done] <= 1'b1;
      end
      if (conv_start && busy_q) begin
        status_q[adc_ctrl_pkg::ev_restart] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // step pacing and successive approximation
  adc_step_timer u_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (conv_start),
    .run     (busy_q && powered),
    .step_en (step_en)
  );

  adc_sar_core u_sar (
    .clk        (clk),
    .rst_b      (rst_b),
    .begin_conv (conv_start),
    .step_en    (step_en),
    .comp_high  (comp_high),
    .trial_code (trial_code),
    .finished   (finished)
  );

  // ==========================================================================
  // register read, data one cycle after the strobe
  always_comb begin
    control_view = {conv_irq_enable_q, end_conv_q, 1'b0, conv_power_select_q,
                    control_reserved_3_q, main_osc_disable_q,
                    control_reserved_lo_q};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        adc_ctrl_pkg::result_offset:  rdata_q <= result_q;
        adc_ctrl_pkg::control_offset: rdata_q <= control_view;
        adc_ctrl_pkg::status_offset:  rdata_q <= {6'h00, status_q};
        adc_ctrl_pkg::mask_offset:    rdata_q <= {6'h00, mask_q};
        default:                      rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata            = rdata_q;
  assign dac_code         = trial_code;
  assign conv_power_on    = powered;
  assign sample_active    = busy_q;
  assign main_osc_disable = main_osc_disable_q;
  assign conv_irq         = conv_irq_enable_q && end_conv_q;
  assign wake_request     = conv_irq && !stop_q;
  assign irq              = |(status_q & mask_q);

endmodule

//--- tb/adc_control_sva.sv
`timescale 1ns/1ns
// ==========================================
// port checker for the converter control
module adc_control_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] dac_code,
  input wire logic       conv_power_on,
  input wire logic       sample_active,
  input wire logic       main_osc_disable,
  input wire logic       stop_mode,
  input wire logic       conv_irq,
  input wire logic       wake_request
);
  localparam logic [7:0] ctl = adc_ctrl_pkg::control_offset;
  logic        start_w;
  logic [11:0] run_cnt_q;
  // start request seen on the bus
  assign start_w = wr && addr == ctl && wdata[5];
  // cycles spent in one conversion attempt
  always_ff @(posedge clk) begin
    if (!rst_b || !sample_active || start_w) begin
      run_cnt_q <= 12'h000;
    end else begin
      run_cnt_q <= run_cnt_q + 12'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ctl_wr; wr && addr == ctl; endsequence
  sequence s_start; s_ctl_wr ##0 wdata[5]; endsequence
  sequence s_ctl_rd; rd && addr == ctl; endsequence
  sequence s_no_stop; !stop_mode [*6]; endsequence
  property p_start_run; s_start ##0 (wdata[4] && conv_power_on) |=> sample_active && dac_code == 8'h80; endproperty
  a_start_run: assert property (p_start_run) else $error("no start at msb");
  property p_start_clr; s_start |=> !conv_irq; endproperty
  a_start_clr: assert property (p_start_clr) else $error("start kept irq");
  property p_sta_zero; s_ctl_rd |=> !rdata[5]; endproperty
  a_sta_zero: assert property (p_sta_zero) else $error("start bit read one");
  property p_irq_flag; s_ctl_rd |=> $past(conv_irq) == (rdata[7] && rdata[6]); endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq not enable and flag");
  property p_busy_flag; s_ctl_rd ##0 sample_active |=> !rdata[6]; endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("flag set while busy");
  property p_osc; s_ctl_wr |=> main_osc_disable == $past(wdata[2]); endproperty
  a_osc: assert property (p_osc) else $error("osc bit wrong");
  property p_power; s_no_stop ##0 s_ctl_wr |=> conv_power_on == $past(wdata[4]); endproperty
  a_power: assert property (p_power) else $error("power bit wrong");
  property p_stop; stop_mode [*6] |-> !conv_power_on && !wake_request; endproperty
  a_stop: assert property (p_stop) else $error("stop left converter on");
  property p_wake; wake_request |-> conv_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  property p_conv_time; run_cnt_q <= 12'(adc_ctrl_pkg::conv_cycles + 4); endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion too long");
endmodule

bind adc_control adc_control_chk adc_control_chk_i (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dac_code(dac_code),
  .conv_power_on(conv_power_on), .sample_active(sample_active),
  .main_osc_disable(main_osc_disable), .stop_mode(stop_mode), .conv_irq(conv_irq),
  .wake_request(wake_request));

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, comp_high = 1'b0;
  logic       wait_mode = 1'b0, stop_mode = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ain = 8'h00, rdata, dac_code;
  logic       conv_power_on, sample_active, main_osc_disable, conv_irq, wake_request, irq;
  int         error_cnt = 0, comparisons = 0, n;
  // ==========================================
  // clock, analog input model, design
  always #25 clk = ~clk;
  always @(posedge clk) comp_high <= (ain >= dac_code);
  adc_control adc_control_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .comp_high(comp_high), .dac_code(dac_code),
    .conv_power_on(conv_power_on), .sample_active(sample_active),
    .main_osc_disable(main_osc_disable), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .conv_irq(conv_irq), .wake_request(wake_request), .irq(irq));
  // ==========================================
  // bus, compare and closing tasks
  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task settle;
    @(posedge clk);
    #1;
  endtask
  // counts cycles from a start write until the run ends
  task wait_done;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (sample_active === 1'b1 && n < 3000);
    if (n >= 3000) begin error_cnt++; stop_test(); end
    chk(8'(n >= adc_ctrl_pkg::conv_cycles - 4 && n <= adc_ctrl_pkg::conv_cycles + 4), 8'h01);
  endtask
  // ==========================================
  // scenarios
  task t_convert(input logic [7:0] v);
    ain = v;
    wr_reg(8'hd1, 8'h10);
    wr_reg(8'hd1, 8'h30);
    wait_done();
    rdchk(8'hd1, 8'h50);
    rdchk(8'hd0, v);
    rdchk(8'hd2, 8'h01);
  endtask
  task t_read_only;
    wr_reg(8'hd1, 8'h10);
    wr_reg(8'hd0, 8'h33);
    rdchk(8'hd1, 8'h50);
    rdchk(8'hd0, 8'h5a);
  endtask
  task t_irq;
    wr_reg(8'hd3, 8'h01);
    wr_reg(8'hd2, 8'h00);
    wr_reg(8'hd1, 8'h90); settle();
    chk({5'h00, irq, conv_irq, wake_request}, 8'h07);
    wr_reg(8'hd3, 8'h00); settle();
    chk(8'(irq), 8'h00);
    wr_reg(8'hd3, 8'h01);
    wr_reg(8'hd2, 8'h01); settle();
    chk(8'(irq), 8'h00);
    rdchk(8'hd3, 8'h01);
    wr_reg(8'hd1, 8'hb0); settle();
    chk(8'(conv_irq), 8'h00);
    wait_done(); settle();
    chk({6'h00, irq, conv_irq}, 8'h03);
    wr_reg(8'hd2, 8'h03);
    // handler drops the enable so the standing flag stops interrupting
    wr_reg(8'hd1, 8'h10);
    settle();
    chk(8'(conv_irq), 8'h00);
  endtask
  task t_restart;
    wait_mode <= 1'b1;
    wr_reg(8'hd1, 8'h30);
    rdchk(8'hd1, 8'h10);
    repeat (300) @(posedge clk);
    wr_reg(8'hd1, 8'h30);
    wait_done();
    rdchk(8'hd2, 8'h03);
    wr_reg(8'hd2, 8'h03);
    wait_mode <= 1'b0;
  endtask
  task t_power_off;
    wr_reg(8'hd1, 8'h00);
    wr_reg(8'hd1, 8'h20);
    repeat (4) settle();
    chk(8'(sample_active), 8'h00);
    rdchk(8'hd1, 8'h00);
  endtask
  task t_osc;
    wr_reg(8'hd1, 8'h04); settle();
    chk(8'(main_osc_disable), 8'h01);
    rdchk(8'hd1, 8'h04);
  endtask
  task t_stop;
    t_convert(8'h3c);
    wr_reg(8'hd1, 8'h90);
    @(posedge clk) stop_mode <= 1'b1;
    repeat (8) settle();
    chk({6'h00, conv_power_on, wake_request}, 8'h00);
    @(posedge clk) stop_mode <= 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(8'hd1, 8'h40);
    rdchk(8'hd0, 8'h00);
    rdchk(8'h7e, 8'h00);
    t_convert(8'h00);
    t_convert(8'hff);
    t_convert(8'ha5);
    t_convert(8'h5a);
    t_read_only();
    t_irq();
    t_restart();
    t_power_off();
    t_osc();
    t_stop();
    stop_test();
  end
endmodule
